// file: design/csc_field_dec.sv
module csc_field_dec (
	csc_pick_if.decoder dif
);
	assign dif.setup_hot = 8'h01 << dif.setup;

	always_comb begin
		dif.in_num  = 2'h0;
		dif.in_rsvd = 1'b0;
		case (dif.pin_code)
			csc_pkg::IN_FIRST:  dif.in_num = 2'h0;
			csc_pkg::IN_SECOND: dif.in_num = 2'h1;
			csc_pkg::IN_THIRD:  dif.in_num = 2'h2;
			csc_pkg::IN_FOURTH: dif.in_num = 2'h3;
			default:            dif.in_rsvd = 1'b1;
		endcase
	end
endmodule // csc_field_dec

// file: design/csc_pick_if.sv
interface csc_pick_if;
	logic [15:0] enables;
	logic [3:0]  cur;
	logic [3:0]  next_ch;
	logic [3:0]  lowest;
	logic        any;
	logic [2:0]  setup;
	logic [4:0]  pin_code;
	logic [7:0]  setup_hot;
	logic [1:0]  in_num;
	logic        in_rsvd;

	modport picker (input enables, input cur, output next_ch, output lowest,
		output any);
	modport decoder (input setup, input pin_code, output setup_hot,
		output in_num, output in_rsvd);
	modport user (output enables, output cur, output setup, output pin_code,
		input next_ch, input lowest, input any, input setup_hot,
		input in_num, input in_rsvd);
endinterface

// file: design/csc_pkg.sv
// What this block does
// - sixteen slot registers, consecutive indices, slot0 lowest
// - reset: slot0 active, others same but inactive
// - bit 23 admits slot into rotation
// - lowest active first, ascend, wrap around
// - result written loads channel into status nibble
// - bits 22:20 pick one of eight setups
// - setup n is its four registers; shareable
// - bit 18 limit watch, void without fifo
// - bits 17:13 positive input code map
package csc_pkg;
	localparam int          SLOT_COUNT    = 16;
	localparam int          SLOT_W        = 24;
	localparam int          IDX_W         = 8;
	localparam logic [7:0]  SLOT0_IDX     = 8'h09;
	localparam logic [7:0]  SLOT_LAST_IDX = 8'h18;
	localparam logic [7:0]  STATUS_IDX    = 8'h00;
	localparam int          ACTIVE_BIT    = 23;
	localparam int          SETUP_LSB     = 20;
	localparam int          SETUP_W       = 3;
	localparam int          SETUP_COUNT   = 8;
	localparam int          LIMIT_BIT     = 18;
	localparam int          INPUT_LSB     = 13;
	localparam int          INPUT_W       = 5;
	localparam logic [23:0] SLOT0_RST     = 24'h800100;
	localparam logic [23:0] SLOT_RST      = 24'h000100;
	localparam logic [4:0]  IN_FIRST      = 5'h00;
	localparam logic [4:0]  IN_SECOND     = 5'h01;
	localparam logic [4:0]  IN_THIRD      = 5'h04;
	localparam logic [4:0]  IN_FOURTH     = 5'h05;
	localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0]  HRESP_OKAY    = 2'h0;
endpackage

// file: design/csc_seq_pick.sv
module csc_seq_pick (
	csc_pick_if.picker pif
);
	logic [15:0] above;
	logic [3:0]  low_c;
	logic [3:0]  up_c;
	logic        up_hit;

	// mask of active slots strictly above the current one
	genvar g;
	generate
		for (g = 0; g < csc_pkg::SLOT_COUNT; g++) begin : g_above
			assign above[g] = pif.enables[g] && (4'(g) > pif.cur);
		end
	endgenerate

	always_comb begin
		low_c  = 4'h0;
		up_c   = 4'h0;
		up_hit = 1'b0;
		for (int i = csc_pkg::SLOT_COUNT - 1; i >= 0; i--) begin
			if (pif.enables[i]) begin
				low_c = 4'(i);
			end
			if (above[i]) begin
				up_c   = 4'(i);
				up_hit = 1'b1;
			end
		end
	end

	assign pif.lowest  = low_c;
	assign pif.next_ch = up_hit ? up_c : low_c;
	assign pif.any     = |pif.enables;
endmodule // csc_seq_pick

// file: design/csc_top.sv
module csc_top (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic      [1:0]  hresp,
	input  wire logic        seq_start,
	input  wire logic        result_written,
	input  wire logic        fifo_enable,
	output logic      [3:0]  conv_channel,
	output logic      [2:0]  conv_setup,
	output logic      [7:0]  conv_setup_hot,
	output logic      [4:0]  positive_input_choice,
	output logic      [1:0]  conv_input_num,
	output logic             conv_input_rsvd,
	output logic             limit_watch_flag,
	output logic             seq_any
);
	typedef struct packed {
		logic [15:0][23:0] slot;
		logic [3:0]        cur;
		logic [3:0]        status;
		logic              wr_pend;
		logic [7:0]        wr_idx;
		logic [31:0]       rdata;
		logic [3:0]        out_ch;
		logic [2:0]        out_setup;
		logic [7:0]        out_hot;
		logic [4:0]        out_pin;
		logic [1:0]        out_num;
		logic              out_rsvd;
		logic              out_watch;
		logic              out_any;
	} csc_state_t;

	csc_state_t  st_ff;
	csc_state_t  nxt_st;
	csc_pick_if  pif ();

	logic        acc;
	logic        mapped;
	logic [7:0]  a_idx;
	logic [7:0]  a_off;
	logic [7:0]  w_off;
	logic        w_hit;
	logic [23:0] cur_slot;
	logic [23:0] rd_slot;

	csc_seq_pick u_pick (
		.pif (pif)
	);

	csc_field_dec u_dec (
		.dif (pif)
	);

	// per-slot active flags feed the rotation
	genvar g;
	generate
		for (g = 0; g < csc_pkg::SLOT_COUNT; g++) begin : g_en
			assign pif.enables[g] = st_ff.slot[g][csc_pkg::ACTIVE_BIT];
		end
	endgenerate

	assign cur_slot     = st_ff.slot[st_ff.cur];
	assign pif.cur      = st_ff.cur;
	assign pif.setup    = cur_slot[csc_pkg::SETUP_LSB +: csc_pkg::SETUP_W];
	assign pif.pin_code = cur_slot[csc_pkg::INPUT_LSB +: csc_pkg::INPUT_W];

	// address phase decode, word index is haddr[9:2]
	assign acc    = hsel && (htrans == csc_pkg::HTRANS_NONSEQ) && hready;
	assign a_idx  = haddr[9:2];
	assign mapped = (haddr[31:10] == 22'h0) && (haddr[1:0] == 2'h0);
	assign a_off  = a_idx - csc_pkg::SLOT0_IDX;
	assign w_off  = st_ff.wr_idx - csc_pkg::SLOT0_IDX;
	assign w_hit  = st_ff.wr_pend
		&& (st_ff.wr_idx >= csc_pkg::SLOT0_IDX)
		&& (st_ff.wr_idx <= csc_pkg::SLOT_LAST_IDX);

	// forward a pending write so a back-to-back read sees it
	assign rd_slot = (w_hit && (st_ff.wr_idx == a_idx))
		? hwdata[23:0] : st_ff.slot[a_off[3:0]];

	always_comb begin
		nxt_st = st_ff;
		if (w_hit) begin
			nxt_st.slot[w_off[3:0]] = hwdata[23:0];
		end
		nxt_st.wr_pend = acc && hwrite && mapped;
		nxt_st.wr_idx  = a_idx;
		if (acc && !hwrite) begin
			if (!mapped) begin
				nxt_st.rdata = 32'h0;
			end else if (a_idx == csc_pkg::STATUS_IDX) begin
				nxt_st.rdata = {28'h0, st_ff.status};
			end else if ((a_idx >= csc_pkg::SLOT0_IDX)
				&& (a_idx <= csc_pkg::SLOT_LAST_IDX)) begin
				nxt_st.rdata = {8'h0, rd_slot};
			end else begin
				nxt_st.rdata = 32'h0;
			end
		end
		if (result_written) begin
			nxt_st.status = st_ff.cur;
		end
		if (seq_start) begin
			nxt_st.cur = pif.lowest;
		end else if (result_written) begin
			nxt_st.cur = pif.next_ch;
		end
		nxt_st.out_ch    = st_ff.cur;
		nxt_st.out_setup = pif.setup;
		nxt_st.out_hot   = pif.setup_hot;
		nxt_st.out_pin   = pif.pin_code;
		nxt_st.out_num   = pif.in_num;
		nxt_st.out_rsvd  = pif.in_rsvd;
		nxt_st.out_watch = cur_slot[csc_pkg::LIMIT_BIT] && fifo_enable;
		nxt_st.out_any   = pif.any;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_ff <= '0;
			st_ff.slot[0] <= csc_pkg::SLOT0_RST;
			for (int i = 1; i < csc_pkg::SLOT_COUNT; i++) begin
				st_ff.slot[i] <= csc_pkg::SLOT_RST;
			end
			st_ff.out_any <= 1'b1;
			st_ff.out_hot <= 8'h01;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// zero-wait slave, always OKAY
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
		end
	end

	assign hresp                 = csc_pkg::HRESP_OKAY;
	assign hrdata                = st_ff.rdata;
	assign conv_channel          = st_ff.out_ch;
	assign conv_setup            = st_ff.out_setup;
	assign conv_setup_hot        = st_ff.out_hot;
	assign positive_input_choice = st_ff.out_pin;
	assign conv_input_num        = st_ff.out_num;
	assign conv_input_rsvd       = st_ff.out_rsvd;
	assign limit_watch_flag      = st_ff.out_watch;
	assign seq_any               = st_ff.out_any;

	// helper: no register write has landed since reset
	logic chk_fresh_ff;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			chk_fresh_ff <= 1'b1;
		end else if (w_hit) begin
			chk_fresh_ff <= 1'b0;
		end
	end

	chk_slot_base_write: assert property (@(posedge hclk) disable iff (!hresetn)
		(st_ff.wr_pend && st_ff.wr_idx == csc_pkg::SLOT0_IDX)
		|=> st_ff.slot[0] == $past(hwdata[23:0]))
		else $error("slot0 write not stored");

	chk_slot_last_write: assert property (@(posedge hclk) disable iff (!hresetn)
		(st_ff.wr_pend && st_ff.wr_idx == csc_pkg::SLOT_LAST_IDX)
		|=> st_ff.slot[15] == $past(hwdata[23:0]))
		else $error("slot15 write not stored");

	chk_reset_values: assert property (@(posedge hclk) disable iff (!hresetn)
		chk_fresh_ff |-> (st_ff.slot[0] == csc_pkg::SLOT0_RST
		&& st_ff.slot[1] == csc_pkg::SLOT_RST
		&& st_ff.slot[15] == csc_pkg::SLOT_RST))
		else $error("slot reset value wrong");

	chk_active_only: assert property (@(posedge hclk) disable iff (!hresetn)
		(result_written && !seq_start && pif.any && !w_hit)
		|=> st_ff.slot[st_ff.cur][csc_pkg::ACTIVE_BIT])
		else $error("sequencer landed on inactive slot");

	chk_seq_ascend_wrap: assert property (@(posedge hclk) disable iff (!hresetn)
		(result_written && !seq_start)
		|=> (st_ff.cur > $past(st_ff.cur)) || (st_ff.cur == $past(pif.lowest)))
		else $error("sequencer order wrong");

	chk_seq_start_low: assert property (@(posedge hclk) disable iff (!hresetn)
		seq_start |=> st_ff.cur == $past(pif.lowest) ##1
		conv_channel == $past(pif.lowest, 2))
		else $error("start not at lowest active slot");

	chk_status_tag: assert property (@(posedge hclk) disable iff (!hresetn)
		result_written |=> st_ff.status == $past(st_ff.cur))
		else $error("status nibble not loaded");

	chk_setup_follow: assert property (@(posedge hclk) disable iff (!hresetn)
		conv_setup == $past(st_ff.slot[st_ff.cur][22:20]))
		else $error("setup output mismatch");

	chk_setup_onehot: assert property (@(posedge hclk) disable iff (!hresetn)
		$onehot(conv_setup_hot) && conv_setup_hot[conv_setup])
		else $error("setup one-hot mismatch");

	chk_watch_gated: assert property (@(posedge hclk) disable iff (!hresetn)
		!$past(fifo_enable) |-> !limit_watch_flag)
		else $error("limit watch active without fifo");

	chk_input_third: assert property (@(posedge hclk) disable iff (!hresetn)
		(positive_input_choice == csc_pkg::IN_THIRD)
		|-> (conv_input_num == 2'h2 && !conv_input_rsvd))
		else $error("third input code decoded wrong");

	chk_input_rsvd: assert property (@(posedge hclk) disable iff (!hresetn)
		(positive_input_choice == 5'h02 || positive_input_choice == 5'h03)
		|-> conv_input_rsvd)
		else $error("reserved input code not flagged");
endmodule // csc_top

// file: verif/csc_tb.sv
module testbench;
	timeunit 1ns;
	timeprecision 1ps;

`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin miscompares++; \
	$display("Error at %0t: got %h expected %h", $time, g, e); end end

	logic        hclk           = 1'b0;
	logic        hresetn        = 1'b0;
	logic        hsel           = 1'b0;
	logic        hwrite         = 1'b0;
	logic [31:0] haddr          = 32'h0;
	logic [31:0] hwdata         = 32'h0;
	logic [1:0]  htrans         = 2'h0;
	logic        seq_start      = 1'b0;
	logic        result_written = 1'b0;
	logic        fifo_enable    = 1'b0;
	logic        look           = 1'b0;
	logic        rdp            = 1'b0;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic [1:0]  hresp;
	logic [3:0]  conv_channel;
	logic [2:0]  conv_setup;
	logic [7:0]  conv_setup_hot;
	logic [4:0]  positive_input_choice;
	logic [1:0]  conv_input_num;
	logic        conv_input_rsvd;
	logic        limit_watch_flag;
	logic        seq_any;
	int          miscompares    = 0;
	int          n_checks       = 0;
	int          cyc            = 0;
	logic [23:0] mdl [16];
	logic [3:0]  cur;
	logic [3:0]  stat;
	logic [31:0] e32;
	logic [24:0] e25;
	logic [31:0] d;
	logic [31:0] rq [$];
	logic [24:0] cq [$];
	logic [4:0]  codes [8] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05,
		5'h1F, 5'h0A};

	always #25 hclk = ~hclk;

	csc_top dut (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .seq_start(seq_start), .result_written(result_written),
		.fifo_enable(fifo_enable), .conv_channel(conv_channel),
		.conv_setup(conv_setup), .conv_setup_hot(conv_setup_hot),
		.positive_input_choice(positive_input_choice),
		.conv_input_num(conv_input_num), .conv_input_rsvd(conv_input_rsvd),
		.limit_watch_flag(limit_watch_flag), .seq_any(seq_any)
	);

	task automatic stop_test();
		if (miscompares == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic bus(input logic [31:0] a, input logic wr,
		input logic [31:0] wd);
		hsel <= 1'b1;
		htrans <= csc_pkg::HTRANS_NONSEQ;
		haddr <= a;
		hwrite <= wr;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
	endtask

	task automatic rd(input logic [31:0] a, input logic [31:0] e);
		rq.push_back(e);
		bus(a, 1'b0, 32'h0);
	endtask

	// lowest active slot above the given index, else lowest overall
	function automatic logic [3:0] pick(input int above);
		for (int i = 0; i < 16; i++)
			if (mdl[i][csc_pkg::ACTIVE_BIT] && i > above)
				return 4'(i);
		return (above < 0) ? 4'h0 : pick(-1);
	endfunction

	function automatic logic [24:0] conv(input logic [3:0] c);
		logic [23:0] s;
		logic        rs;
		logic [1:0]  n;
		logic        any;
		s = mdl[c];
		rs = !(s[17:13] inside {csc_pkg::IN_FIRST, csc_pkg::IN_SECOND,
			csc_pkg::IN_THIRD, csc_pkg::IN_FOURTH});
		n = rs ? 2'h0 : (s[17:13] == csc_pkg::IN_FOURTH) ? 2'h3 :
			(s[17:13] == csc_pkg::IN_THIRD) ? 2'h2 : s[14:13];
		any = 1'b0;
		for (int i = 0; i < 16; i++)
			any |= mdl[i][csc_pkg::ACTIVE_BIT];
		return {c, s[22:20], 8'h01 << s[22:20], s[17:13], n, rs,
			s[18] & fifo_enable, any};
	endfunction

	task automatic pulse(input logic start);
		if (start)
			seq_start <= 1'b1;
		else
			result_written <= 1'b1;
		fifo_enable <= 1'($urandom);
		@(posedge hclk);
		seq_start <= 1'b0;
		result_written <= 1'b0;
		if (!start)
			stat = cur;
		cur = start ? pick(-1) : pick(int'(cur));
		@(posedge hclk);
		cq.push_back(conv(cur));
		look <= 1'b1;
		@(posedge hclk);
		look <= 1'b0;
		rd(32'h0, {28'h0, stat});
	endtask

	always @(posedge hclk) begin
		if (rdp && hreadyout === 1'b1) begin
			e32 = rq.pop_front();
			`CHK(hrdata, e32)
		end
		if (look) begin
			e25 = cq.pop_front();
			`CHK({conv_channel, conv_setup, conv_setup_hot, positive_input_choice, conv_input_rsvd ? 2'h0 : conv_input_num, conv_input_rsvd, limit_watch_flag, seq_any}, e25)
		end
		rdp = hsel && htrans == csc_pkg::HTRANS_NONSEQ && !hwrite && hreadyout;
	end

	always @(posedge hclk) begin
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			stop_test();
		end
	end

	initial begin
		void'($urandom(60));
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		for (int m = 0; m < 16; m++)
			mdl[m] = (m == 0) ? csc_pkg::SLOT0_RST : csc_pkg::SLOT_RST;
		cur = 4'h0;
		stat = 4'h0;
		cq.push_back(conv(4'h0));
		look <= 1'b1;
		@(posedge hclk);
		look <= 1'b0;
		for (int m = 0; m < 16; m++)
			rd(32'h24 + 32'(4 * m), {8'h00, mdl[m]});
		rd(32'h0, 32'h0);
		rd(32'h4, 32'h0);
		bus(32'h64, 1'b1, $urandom);
		rd(32'h64, 32'h0);
		for (int r = 0; r < 3; r++) begin
			for (int m = 0; m < 16; m++) begin
				d = $urandom;
				d[22:20] = 3'(m + r);
				d[17:13] = codes[(m + r) % 8];
				if (r == 2)
					d[23] = 1'b0;
				bus(32'h24 + 32'(4 * m), 1'b1, d);
				mdl[m] = d[23:0];
				if (m % 3 == 0)
					rd(32'h24 + 32'(4 * m), {8'h00, d[23:0]});
			end
			pulse(1'b1);
			repeat (18) pulse(1'b0);
		end
		stop_test();
	end
endmodule // testbench
